//--- hw/amsc_pkg.sv
// Package for the alert mask and capacity smoothing configuration bank.
// Assumes a single 100 MHz clock domain and an APB register port.
package amsc_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] AMSC_OFF_LRN_LO  = 8'h00;
  localparam logic [7:0] AMSC_OFF_LRN_HI  = 8'h04;
  localparam logic [7:0] AMSC_OFF_SVC     = 8'h08;
  localparam logic [7:0] AMSC_OFF_SAFETY  = 8'h0C;
  localparam logic [7:0] AMSC_OFF_OPER    = 8'h10;
  localparam logic [7:0] AMSC_OFF_SMOOTH  = 8'h14;
  localparam logic [7:0] AMSC_OFF_IRQ_ST  = 8'h18;
  localparam logic [7:0] AMSC_OFF_IRQ_MSK = 8'h1C;
  localparam logic [7:0] AMSC_OFF_ACTIVE  = 8'h20;

  // ---------------------------------------------------------------
  // Writable bit masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] AMSC_WMASK_FULL   = 8'hFF;
  localparam logic [7:0] AMSC_WMASK_SVC    = 8'hDF;
  localparam logic [7:0] AMSC_WMASK_SAFETY = 8'h77;
  localparam logic [7:0] AMSC_WMASK_OPER   = 8'h03;
  localparam logic [7:0] AMSC_WMASK_SMOOTH = 8'h0F;
  localparam logic [7:0] AMSC_MASK_RST     = 8'h00;
  localparam logic [7:0] AMSC_SMOOTH_RST   = 8'h00;
  localparam logic [4:0] AMSC_IRQ_RST      = 5'h00;

  // Smoothing field positions
  localparam int AMSC_SM_EOC_BIT = 3;
  localparam int AMSC_SM_EXT_BIT = 2;
  localparam int AMSC_SM_SMOOTHING_VOLTAGE_SOURCE_BIT = 1;
  localparam int AMSC_SM_REP_BIT = 0;

  localparam int AMSC_NGRP = 5;

  // Status flags from the gauge core
  typedef struct packed {
    logic [7:0] learn_lo;
    logic [7:0] learn_hi;
    logic [7:0] service;
    logic [7:0] safety_hi;
    logic [7:0] safety_lo;
    logic [1:0] oper;
  } amsc_status_t;

  // Decoded smoothing controls
  typedef struct packed {
    logic end_of_charge_smoothing_enable;
    logic smoothing_extent_select;
    logic smoothing_voltage_source;
    logic smoothed_report_select;
  } amsc_smooth_t;

endpackage

//--- hw/amsc_bank.sv
// Alert mask and capacity smoothing configuration bank with APB slave.
// Assumes status flags and capacities come from logic on ref_clk.
// Notes on behaviour
// - Learning status low byte alert mask
// - Learning status high byte alert mask
// - Service status mask, bit 5 reserved
// - Safety mask: warnings high nibble, alerts low
// - Operation mask: only bits 1 and 0
// - All masks reset to zero
// - Bit 3 enables end-of-charge smoothing
// - Bit 2 extends smoothing past first threshold
// - Bit 1 selects averaged voltage
// - Bit 0 reports smoothed capacity
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module amsc_bank
  import amsc_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire amsc_status_t  status_flags,
  input  wire logic [15:0]   comp_capacity,
  input  wire logic [15:0]   smooth_capacity,
  output amsc_smooth_t       smooth_ctrl,
  output logic [15:0]        remaining_capacity,
  output logic               alert,
  output logic               irq
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire       acc     = psel && penable;
  wire       wr_acc  = acc && pwrite && pstrb[0];
  wire       hit_llo = paddr == AMSC_OFF_LRN_LO;
  wire       hit_lhi = paddr == AMSC_OFF_LRN_HI;
  wire       hit_svc = paddr == AMSC_OFF_SVC;
  wire       hit_saf = paddr == AMSC_OFF_SAFETY;
  wire       hit_opr = paddr == AMSC_OFF_OPER;
  wire       hit_smo = paddr == AMSC_OFF_SMOOTH;
  wire       hit_ist = paddr == AMSC_OFF_IRQ_ST;
  wire       hit_ims = paddr == AMSC_OFF_IRQ_MSK;
  wire       hit_act = paddr == AMSC_OFF_ACTIVE;
  wire       mapped  = hit_llo | hit_lhi | hit_svc | hit_saf | hit_opr |
                       hit_smo | hit_ist | hit_ims | hit_act;
  wire [7:0] wbyte   = pwdata[7:0];

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = psel && penable;
  assign pslverr = acc && !mapped;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] llo_q, lhi_q, svc_q, saf_q, opr_q, smo_q;
  logic [7:0] llo_d, lhi_d, svc_d, saf_d, opr_d, smo_d;

  // Reserved bits are never stored, so they read as zero
  assign llo_d = (wr_acc && hit_llo) ? (wbyte & AMSC_WMASK_FULL)   : llo_q;
  assign lhi_d = (wr_acc && hit_lhi) ? (wbyte & AMSC_WMASK_FULL)   : lhi_q;
  assign svc_d = (wr_acc && hit_svc) ? (wbyte & AMSC_WMASK_SVC)    : svc_q;
  assign saf_d = (wr_acc && hit_saf) ? (wbyte & AMSC_WMASK_SAFETY) : saf_q;
  assign opr_d = (wr_acc && hit_opr) ? (wbyte & AMSC_WMASK_OPER)   : opr_q;
  assign smo_d = (wr_acc && hit_smo) ? (wbyte & AMSC_WMASK_SMOOTH) : smo_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      llo_q <= AMSC_MASK_RST;
      lhi_q <= AMSC_MASK_RST;
      svc_q <= AMSC_MASK_RST;
      saf_q <= AMSC_MASK_RST;
      opr_q <= AMSC_MASK_RST;
      smo_q <= AMSC_SMOOTH_RST;
    end else begin
      llo_q <= llo_d;
      lhi_q <= lhi_d;
      svc_q <= svc_d;
      saf_q <= saf_d;
      opr_q <= opr_d;
      smo_q <= smo_d;
    end
  end

  // ---------------------------------------------------------------
  // Smoothing controls and reported capacity
  // ---------------------------------------------------------------
  assign smooth_ctrl.end_of_charge_smoothing_enable = smo_q[AMSC_SM_EOC_BIT];
  assign smooth_ctrl.smoothing_extent_select        = smo_q[AMSC_SM_EXT_BIT];
  assign smooth_ctrl.smoothing_voltage_source       = smo_q[AMSC_SM_SMOOTHING_VOLTAGE_SOURCE_BIT];
  assign smooth_ctrl.smoothed_report_select         = smo_q[AMSC_SM_REP_BIT];

  logic [15:0] cap_q;
  wire  [15:0] cap_d = smo_q[AMSC_SM_REP_BIT] ? smooth_capacity : comp_capacity;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cap_q <= 16'h0000;
    end else begin
      cap_q <= cap_d;
    end
  end
  assign remaining_capacity = cap_q;

  // ---------------------------------------------------------------
  // Alert combining, one group per mask register
  // ---------------------------------------------------------------
  wire [7:0] grp_flag [AMSC_NGRP];
  wire [7:0] grp_mask [AMSC_NGRP];
  wire [AMSC_NGRP-1:0] grp_hit;

  assign grp_flag[0] = status_flags.learn_lo;
  assign grp_flag[1] = status_flags.learn_hi;
  assign grp_flag[2] = status_flags.service;
  // Safety warnings sit in the high nibble, alerts in the low one
  assign grp_flag[3] = {status_flags.safety_hi[3:0], status_flags.safety_lo[3:0]};
  assign grp_flag[4] = {6'h00, status_flags.oper};
  assign grp_mask[0] = llo_q;
  assign grp_mask[1] = lhi_q;
  assign grp_mask[2] = svc_q;
  assign grp_mask[3] = saf_q;
  assign grp_mask[4] = opr_q;

  genvar g;
  generate
    for (g = 0; g < AMSC_NGRP; g++) begin : g_grp
      assign grp_hit[g] = |(grp_flag[g] & grp_mask[g]);
    end
  endgenerate

  logic alert_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= |grp_hit;
    end
  end
  assign alert = alert_q;

  // ---------------------------------------------------------------
  // Interrupts: rising edge of a group hit sets a sticky bit
  // ---------------------------------------------------------------
  logic [AMSC_NGRP-1:0] hit_prev_q, ist_q, ist_d, ims_q, ims_d;
  wire  [AMSC_NGRP-1:0] ev  = grp_hit & ~hit_prev_q;
  wire  [AMSC_NGRP-1:0] w1c = (wr_acc && hit_ist) ? wbyte[AMSC_NGRP-1:0] : '0;

  // Set beats clear so an event in the clearing cycle survives
  assign ist_d = (ist_q & ~w1c) | ev;
  assign ims_d = (wr_acc && hit_ims) ? wbyte[AMSC_NGRP-1:0] : ims_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hit_prev_q <= AMSC_IRQ_RST;
      ist_q      <= AMSC_IRQ_RST;
      ims_q      <= AMSC_IRQ_RST;
    end else begin
      hit_prev_q <= grp_hit;
      ist_q      <= ist_d;
      ims_q      <= ims_d;
    end
  end
  assign irq = |(ist_q & ims_q);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire [7:0] rsel =
      hit_llo ? llo_q :
      hit_lhi ? lhi_q :
      hit_svc ? svc_q :
      hit_saf ? saf_q :
      hit_opr ? opr_q :
      hit_smo ? smo_q :
      hit_ist ? {3'h0, ist_q} :
      hit_ims ? {3'h0, ims_q} :
      hit_act ? {2'h0, alert_q, grp_hit} : 8'h00;

  logic [31:0] prdata_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= {24'h00_0000, rsel};
    end
  end
  assign prdata = prdata_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_llo_write: assert property (wr_acc && hit_llo |=> llo_q == $past(wbyte))
    else $error("learn low mask write lost");
  chk_lhi_write: assert property (wr_acc && hit_lhi |=> lhi_q == $past(wbyte))
    else $error("learn high mask write lost");
  chk_svc_rsvd: assert property (svc_q[5] == 1'b0)
    else $error("service mask reserved bit set");
  chk_saf_rsvd: assert property (saf_q[7] == 1'b0 && saf_q[3] == 1'b0)
    else $error("safety mask reserved bit set");
  chk_opr_rsvd: assert property (opr_q[7:2] == 6'h00)
    else $error("operation mask reserved bits set");
  chk_reset_zero: assert property (@(posedge ref_clk) $fell(sys_rst) |-> llo_q == 8'h00 && saf_q == 8'h00)
    else $error("mask not zero after reset");
  chk_eoc_ctrl: assert property (wr_acc && hit_smo |=> smooth_ctrl.end_of_charge_smoothing_enable == $past(wbyte[3]))
    else $error("end of charge smoothing control wrong");
  chk_ext_ctrl: assert property (wr_acc && hit_smo |=> smooth_ctrl.smoothing_extent_select == $past(wbyte[2]))
    else $error("smoothing extent control wrong");
  chk_rep_ctrl: assert property (wr_acc && hit_smo |=> smooth_ctrl.smoothed_report_select == $past(wbyte[0]))
    else $error("report select control wrong");
  chk_svc_write: assert property (wr_acc && hit_svc |=> svc_q == ($past(wbyte) & 8'hDF))
    else $error("service mask write lost");
  chk_saf_write: assert property (wr_acc && hit_saf |=> saf_q == ($past(wbyte) & 8'h77))
    else $error("safety mask write lost");
  chk_opr_write: assert property (wr_acc && hit_opr |=> opr_q == ($past(wbyte) & 8'h03))
    else $error("operation mask write lost");
  chk_reset_all: assert property (@(posedge ref_clk) $fell(sys_rst) |-> lhi_q == 8'h00 && svc_q == 8'h00 && opr_q == 8'h00)
    else $error("mask not zero after reset");
  chk_strb_guard: assert property (acc && pwrite && !pstrb[0] |=> $stable(llo_q) && $stable(smo_q))
    else $error("write without byte strobe took effect");
  chk_vsrc_ctrl: assert property (wr_acc && hit_smo |=> smooth_ctrl.smoothing_voltage_source == $past(wbyte[1]))
    else $error("voltage source control wrong");
  chk_cap_select: assert property (##1 remaining_capacity ==
      ($past(smo_q[0]) ? $past(smooth_capacity) : $past(comp_capacity)))
    else $error("reported capacity source wrong");
  chk_alert_or: assert property (##1 alert == (
      (|($past(status_flags.learn_lo) & $past(llo_q))) ||
      (|($past(status_flags.learn_hi) & $past(lhi_q))) ||
      (|($past(status_flags.service) & $past(svc_q) & 8'hDF)) ||
      (|($past(status_flags.safety_hi[3:0]) & $past(saf_q[6:4]))) ||
      (|($past(status_flags.safety_lo[3:0]) & $past(saf_q[2:0]))) ||
      (|($past(status_flags.oper) & $past(opr_q[1:0])))))
    else $error("alert does not follow enabled flags");
  chk_irq_sticky: assert property (ev != '0 |=> (ist_q & $past(ev)) == $past(ev))
    else $error("interrupt event lost");

  cov_alert_rise: cover property (!alert ##1 alert);
  cov_irq_clear: cover property (irq ##1 wr_acc && hit_ist ##1 !irq);
  cov_smooth_rep: cover property (wr_acc && hit_smo && wbyte[0]);
  cov_safety_alert: cover property (grp_hit[3] ##1 alert);

endmodule

//--- dv/test_amsc_bank.sv
// Self-checking bench for the alert mask and capacity smoothing bank.
// Assumes amsc_pkg and amsc_bank are compiled first; the bench drives APB and flags itself.
`timescale 1ns/1ps
module test_amsc_bank
  import amsc_pkg::*;
;
  logic               ref_clk;
  logic               sys_rst;
  logic               psel, penable, pwrite, pready, pslverr, alert, irq;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, v;
  logic [3:0]         pstrb;
  amsc_status_t       status_flags;
  logic [15:0]        comp_capacity, smooth_capacity, remaining_capacity;
  amsc_smooth_t       smooth_ctrl;
  logic [32:0]        exp_q[$];
  logic [31:0]        seed = 32'hd21a;
  logic [7:0]         msk[5];
  int                 n_mismatch = 0;
  int                 cmp_count = 0;
  localparam logic [7:0] OFFS[5] = '{AMSC_OFF_LRN_LO, AMSC_OFF_LRN_HI, AMSC_OFF_SVC, AMSC_OFF_SAFETY, AMSC_OFF_OPER};
  localparam logic [7:0] WM[5] = '{AMSC_WMASK_FULL, AMSC_WMASK_FULL, AMSC_WMASK_SVC, AMSC_WMASK_SAFETY, AMSC_WMASK_OPER};

  amsc_bank dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_flags(status_flags), .comp_capacity(comp_capacity), .smooth_capacity(smooth_capacity),
    .smooth_ctrl(smooth_ctrl), .remaining_capacity(remaining_capacity), .alert(alert), .irq(irq));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reserved mask bits are already stripped from msk, so they cannot contribute
  function automatic logic exp_alert();
    return |(status_flags.learn_lo & msk[0]) | |(status_flags.learn_hi & msk[1]) |
           |(status_flags.service & msk[2]) | |(status_flags.oper & msk[4][1:0]) |
           |({status_flags.safety_hi[3:0], status_flags.safety_lo[3:0]} & msk[3]);
  endfunction

  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000, 4'hf);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------
  // Read monitor: oldest note against {pslverr, prdata}
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check("read", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; pstrb = 4'h0; status_flags = '0;
    comp_capacity = 16'h0000; smooth_capacity = 16'h0000;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(8'(4 * i), 33'h0);
    rd(8'h24, 33'h1_0000_0000);
    apb(1'b1, AMSC_OFF_LRN_LO, 32'h0000_00ff, 4'he);
    rd(AMSC_OFF_LRN_LO, 33'h0);
    for (int k = 0; k < 30; k++) begin
      for (int g = 0; g < 5; g++) begin
        v = rnd();
        msk[g] = v[7:0] & WM[g];
        wr(OFFS[g], v);
        rd(OFFS[g], {25'h0, msk[g]});
      end
      @(posedge ref_clk);
      status_flags <= 42'({rnd(), rnd()} & {rnd(), rnd()});
      settle();
      check("alert", alert, exp_alert());
    end
    for (int i = 0; i < 4; i++) begin
      wr(AMSC_OFF_SMOOTH, 32'h0000_00f0 | (32'h1 << i));
      settle();
      check("smooth_ctrl", smooth_ctrl, 33'(1 << i));
      rd(AMSC_OFF_SMOOTH, 33'(1 << i));
    end
    v = rnd();
    @(posedge ref_clk);
    comp_capacity <= v[15:0];
    smooth_capacity <= v[31:16];
    settle();
    check("remaining_capacity", remaining_capacity, v[15:0]);
    wr(AMSC_OFF_SMOOTH, 32'h0000_0001);
    settle();
    check("remaining_capacity", remaining_capacity, v[31:16]);
    // Interrupt: raise, mask, clear
    @(posedge ref_clk);
    status_flags <= '0;
    settle();
    wr(AMSC_OFF_IRQ_ST, 32'h0000_001f);
    wr(AMSC_OFF_IRQ_MSK, 32'h0000_001f);
    wr(AMSC_OFF_LRN_LO, 32'h0000_00ff);
    settle();
    check("irq", irq, 33'h0);
    @(posedge ref_clk);
    status_flags.learn_lo <= 8'h01;
    settle();
    check("irq", irq, 33'h1);
    rd(AMSC_OFF_IRQ_ST, 33'h01);
    rd(AMSC_OFF_ACTIVE, 33'h21);
    wr(AMSC_OFF_IRQ_MSK, 32'h0000_0000);
    settle();
    check("irq", irq, 33'h0);
    wr(AMSC_OFF_IRQ_ST, 32'h0000_0001);
    wr(AMSC_OFF_IRQ_MSK, 32'h0000_001f);
    settle();
    check("irq", irq, 33'h0);
    rd(AMSC_OFF_IRQ_ST, 33'h0);
    settle();
    report_and_stop();
  end
endmodule
